// ---- core/ppag_consts.vh ----
// constants for the peripheral processor address generation block
`ifndef PPAG_CONSTS_VH
`define PPAG_CONSTS_VH

// accumulator fields
`define PPAG_ACC_W 18
`define PPAG_ACC_MODE_BIT 17
`define PPAG_ACC_ADDR_W 17
// relocation register
`define PPAG_RELOC_W 28
`define PPAG_RELOC_SPARE_W 7
`define PPAG_RELOC_ZERO_W 6
`define PPAG_MS_ADDR_W 28
// local store
`define PPAG_LS_ADDR_W 12
`define PPAG_LS_DATA_W 12
`define PPAG_LS_ONES 12'hFFF
`define PPAG_D_W 6
// main store word
`define PPAG_MS_DATA_W 64
`define PPAG_PACK_N 5
`define PPAG_PACK_CNT_W 3
// opcodes
`define PPAG_OP_LOAD_RELOC 6'h14
`define PPAG_OP_STORE_RELOC 6'h15
`define PPAG_OP_RD_ONE 6'h30
`define PPAG_OP_RD_BLK 6'h31
`define PPAG_OP_WR_ONE 6'h32
`define PPAG_OP_WR_BLK 6'h33
// operand forms
`define PPAG_FORM_NOADDR 3'h0
`define PPAG_FORM_CONST 3'h1
`define PPAG_FORM_DIRECT 3'h2
`define PPAG_FORM_INDEXED 3'h3
`define PPAG_FORM_INDIRECT 3'h4
// inter-processor pacing
`define PPAG_CLK_PERIOD_NS 10
`define PPAG_PASS_FAST_NS 250
`define PPAG_PASS_SLOW_NS 500
`define PPAG_SLOTS 5
`define PPAG_PASS_CNT_W 6
`endif

// ---- core/ppag_fifo.v ----
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module ppag_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clock,
    input wire rst,
    // fill side
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    // drain side
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != DEPTH);
    assign out_valid = (count != 0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage has no reset; only pointers and occupancy count carry state
    always @(posedge clock)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // pointer and occupancy update
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

// ---- core/ppag_core.v ----
// peripheral processor address generation and main store transfer sequencer
`timescale 1ns/100ps
`include "ppag_consts.vh"
module ppag_core #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    // clock and reset
    input wire clock,
    input wire rst,
    // instruction request
    input wire start,
    input wire [5:0] opcode,
    input wire [2:0] form,
    input wire [5:0] d_field,
    input wire [11:0] m_field,
    input wire [17:0] acc,
    input wire [11:0] block_words,
    // operand result
    output reg [17:0] operand,
    output reg [11:0] ls_addr_out,
    output reg busy,
    output reg done,
    // local store port
    output reg ls_en,
    output reg ls_we,
    output reg [11:0] ls_addr,
    output reg [11:0] ls_wdata,
    input wire [11:0] ls_rdata,
    // main store port
    output reg ms_req,
    output reg ms_we,
    output reg [27:0] ms_addr,
    output reg [63:0] ms_wdata,
    input wire ms_ack,
    input wire ms_write_refused,
    input wire [63:0] ms_rdata,
    output reg write_refused,
    // inter-processor passing
    input wire [4:0] self_id,
    input wire [4:0] peer_id,
    input wire pass_valid,
    input wire [11:0] pass_data,
    output reg pass_ready,
    output reg [11:0] chan_reg,
    output reg chan_full,
    input wire chan_read
);
    localparam S_IDLE = 4'h0;
    localparam S_RD_D = 4'h1;
    localparam S_WAIT_D = 4'h2;
    localparam S_RELOC = 4'h3;
    localparam S_MS_REQ = 4'h4;
    localparam S_MS_WAIT = 4'h5;
    localparam S_UNPACK = 4'h6;
    localparam S_PACK_RD = 4'h7;
    localparam S_PACK_WT = 4'h8;
    localparam S_DONE = 4'h9;
    localparam S_PACK_GAP = 4'hA;
    localparam integer FAST_CYC = `PPAG_PASS_FAST_NS / `PPAG_CLK_PERIOD_NS;
    localparam integer SLOW_CYC = `PPAG_PASS_SLOW_NS / `PPAG_CLK_PERIOD_NS;

    reg [3:0] state;
    reg [27:0] reloc;
    reg [11:0] idx_word;
    reg [11:0] cur_ls;
    reg moved;
    reg [11:0] words_left;
    reg [2:0] sub;
    reg [63:0] shift;
    reg [5:0] op;
    reg first_half;
    reg [5:0] pass_cnt;
    reg [5:0] pass_gap;
    wire [12:0] oc_raw;
    wire [11:0] oc_sum;
    wire [11:0] idx_addr;
    wire [27:0] ms_form;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [11:0] fifo_out_data;
    wire [2:0] self_slot;
    wire [2:0] peer_slot;
    wire slow_pass;
    wire fifo_pop;

    // one's complement add with end-around carry
    assign oc_raw = {1'b0, m_field} + {1'b0, idx_word};
    assign oc_sum = oc_raw[11:0] + {11'h000, oc_raw[12]};
    // minus zero folds to plus zero except both minus zero
    assign idx_addr = (oc_sum == `PPAG_LS_ONES &&
        !(m_field == `PPAG_LS_ONES && idx_word == `PPAG_LS_ONES)) ?
        12'h000 : oc_sum;

    // mode taken from live accumulator for every word
    assign ms_form = acc[`PPAG_ACC_MODE_BIT] ?
        (reloc + {11'h000, acc[16:0]}) :
        {11'h000, acc[16:0]};

    // slot is processor number modulo five within its barrel
    function [2:0] slot_of;
        input [4:0] pid;
        reg [3:0] low;
        begin
            low = pid[3:0];
            slot_of = (low >= 4'hA) ? 3'h0 : ((low >= 4'h5) ?
                (low[2:0] - 3'h5) : low[2:0]);
        end
    endfunction
    assign self_slot = slot_of(self_id & 5'h0F);
    assign peer_slot = slot_of(peer_id & 5'h0F);
    assign slow_pass = (self_slot == peer_slot) && (self_id[4] != peer_id[4]);

    assign fifo_pop = fifo_out_valid && !chan_full && (pass_cnt == 6'h00);

    // words bound for the channel register queue here
    ppag_fifo #(
        .WIDTH(12),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_data(pass_data),
        .in_valid(pass_valid && pass_ready),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop)
    );

    // inter-processor channel register, paced per word
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            chan_reg <= 12'h000;
            chan_full <= 1'b0;
            pass_cnt <= 6'h00;
            pass_ready <= 1'b0;
            pass_gap <= 6'h00;
        end
        else
        begin
            // registered ready misses this cycle's push, so it rests after a take
            pass_ready <= fifo_in_ready && !(pass_valid && pass_ready);
            pass_gap <= slow_pass ? SLOW_CYC[5:0] : FAST_CYC[5:0];
            if (pass_cnt != 6'h00)
                pass_cnt <= pass_cnt - 6'h01;
            if (fifo_pop)
            begin
                chan_reg <= fifo_out_data;
                chan_full <= 1'b1;
                pass_cnt <= pass_gap - 6'h01;
            end
            else if (chan_read)
                chan_full <= 1'b0;
        end
    end

    // instruction sequencer
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= S_IDLE;
            reloc <= 28'h0000000;
            idx_word <= 12'h000;
            cur_ls <= 12'h000;
            moved <= 1'b0;
            words_left <= 12'h000;
            sub <= 3'h0;
            shift <= 64'h0;
            op <= 6'h00;
            first_half <= 1'b0;
            operand <= 18'h00000;
            ls_addr_out <= 12'h000;
            busy <= 1'b0;
            done <= 1'b0;
            ls_en <= 1'b0;
            ls_we <= 1'b0;
            ls_addr <= 12'h000;
            ls_wdata <= 12'h000;
            ms_req <= 1'b0;
            ms_we <= 1'b0;
            ms_addr <= 28'h0000000;
            ms_wdata <= 64'h0;
            write_refused <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            ls_en <= 1'b0;
            ls_we <= 1'b0;
            case (state)
            S_IDLE:
            begin
                if (start)
                begin
                    busy <= 1'b1;
                    op <= opcode;
                    moved <= 1'b0;
                    write_refused <= 1'b0;
                    cur_ls <= m_field;
                    words_left <= block_words;
                    case (form)
                    `PPAG_FORM_NOADDR:
                    begin
                        operand <= {12'h000, d_field};
                        state <= S_DONE;
                    end
                    `PPAG_FORM_CONST:
                    begin
                        operand <= {d_field, m_field};
                        state <= S_DONE;
                    end
                    `PPAG_FORM_DIRECT:
                    begin
                        ls_addr_out <= {6'h00, d_field};
                        state <= S_DONE;
                    end
                    `PPAG_FORM_INDEXED:
                    begin
                        if (d_field == 6'h00)
                        begin
                            ls_addr_out <= m_field;
                            state <= S_DONE;
                        end
                        else
                            state <= S_RD_D;
                    end
                    `PPAG_FORM_INDIRECT:
                        state <= S_RD_D;
                    default:
                        state <= S_DONE;
                    endcase
                    ls_en <= (form == `PPAG_FORM_INDIRECT) ||
                        (form == `PPAG_FORM_INDEXED && d_field != 6'h00);
                    ls_addr <= {6'h00, d_field};
                    first_half <= 1'b1;
                    if (opcode == `PPAG_OP_LOAD_RELOC || opcode == `PPAG_OP_STORE_RELOC)
                    begin
                        ls_en <= 1'b1;
                        ls_addr <= m_field;
                        ls_we <= (opcode == `PPAG_OP_STORE_RELOC);
                        ls_wdata <= reloc[27:16];
                        state <= S_RELOC;
                    end
                end
            end
            S_RD_D:
                state <= S_WAIT_D;
            S_WAIT_D:
            begin
                idx_word <= ls_rdata;
                if (form == `PPAG_FORM_INDIRECT)
                begin
                    ls_addr_out <= ls_rdata;
                    cur_ls <= ls_rdata;
                    state <= S_DONE;
                end
                else
                    state <= S_RELOC;
            end
            S_RELOC:
            begin
                if (op == `PPAG_OP_LOAD_RELOC || op == `PPAG_OP_STORE_RELOC)
                begin
                    if (first_half)
                    begin
                        first_half <= 1'b0;
                        ls_en <= 1'b1;
                        ls_addr <= cur_ls + 12'h001;
                        ls_we <= (op == `PPAG_OP_STORE_RELOC);
                        ls_wdata <= {reloc[15:6], 2'h0};
                    end
                    else
                    begin
                        // first word's read data stands only now; spare bits kept zero
                        if (op == `PPAG_OP_LOAD_RELOC)
                            reloc[27:16] <= {`PPAG_RELOC_SPARE_W'h0, ls_rdata[4:0]};
                        state <= S_DONE;
                    end
                end
                else
                begin
                    ls_addr_out <= idx_addr;
                    state <= S_DONE;
                end
            end
            S_MS_REQ:
            begin
                ms_addr <= ms_form;
                ms_req <= 1'b1;
                state <= S_MS_WAIT;
            end
            S_MS_WAIT:
            begin
                if (ms_ack)
                begin
                    ms_req <= 1'b0;
                    ms_we <= 1'b0;
                    // bounds check lives in main store; refusal only reported
                    if (ms_we && ms_write_refused)
                        write_refused <= 1'b1;
                    shift <= ms_rdata;
                    sub <= 3'h0;
                    if (ms_we)
                        state <= (words_left <= 12'h001) ? S_DONE : S_PACK_RD;
                    else
                        state <= S_UNPACK;
                    words_left <= (words_left == 12'h000) ? 12'h000 :
                        words_left - 12'h001;
                end
            end
            S_UNPACK:
            begin
                // upper four bits of the main word are dropped
                ls_en <= 1'b1;
                ls_we <= 1'b1;
                ls_addr <= cur_ls;
                ls_wdata <= shift[59:48];
                shift <= {shift[51:0], 12'h000};
                cur_ls <= cur_ls + 12'h001;
                sub <= sub + 3'h1;
                if (sub == `PPAG_PACK_N - 1)
                    state <= (op == `PPAG_OP_RD_BLK && words_left != 12'h000) ?
                        S_MS_REQ : S_DONE;
            end
            S_PACK_RD:
            begin
                ls_en <= 1'b1;
                ls_addr <= cur_ls;
                cur_ls <= cur_ls + 12'h001;
                state <= S_PACK_GAP;
            end
            // local read data stands only one cycle after the strobe
            S_PACK_GAP:
                state <= S_PACK_WT;
            S_PACK_WT:
            begin
                shift <= {shift[51:0], ls_rdata};
                sub <= sub + 3'h1;
                if (sub == `PPAG_PACK_N - 1)
                begin
                    ms_wdata <= {4'h0, shift[47:0], ls_rdata};
                    ms_we <= 1'b1;
                    state <= S_MS_REQ;
                end
                else
                    state <= S_PACK_RD;
            end
            S_DONE:
            begin
                if (!moved && (op == `PPAG_OP_RD_ONE || op == `PPAG_OP_RD_BLK ||
                    op == `PPAG_OP_WR_ONE || op == `PPAG_OP_WR_BLK))
                begin
                    // hand over to main store traffic once, then finish
                    moved <= 1'b1;
                    sub <= 3'h0;
                    if (op == `PPAG_OP_RD_ONE || op == `PPAG_OP_WR_ONE)
                        words_left <= 12'h001;
                    state <= (op == `PPAG_OP_RD_ONE || op == `PPAG_OP_RD_BLK) ?
                        S_MS_REQ : S_PACK_RD;
                end
                else
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    // second relocation word arrives here, low six forced zero
                    if (op == `PPAG_OP_LOAD_RELOC)
                        reloc[15:0] <= {ls_rdata[11:2], 6'h00};
                    state <= S_IDLE;
                end
            end
            default:
                state <= S_IDLE;
            endcase
        end
    end
endmodule

// ---- dv/ppag_checker.sv ----
// port checker for the address generation core
`timescale 1ns/100ps
`include "ppag_consts.vh"
module ppag_checker (
    // clock and reset
    input wire clock,
    input wire rst,
    // instruction side
    input wire [5:0] opcode,
    input wire [17:0] acc,
    input wire busy,
    input wire done,
    // local store port
    input wire ls_en,
    input wire ls_we,
    // main store port
    input wire ms_req,
    input wire ms_we,
    input wire [27:0] ms_addr,
    input wire [63:0] ms_wdata,
    input wire ms_ack,
    input wire ms_write_refused,
    input wire write_refused,
    // channel
    input wire [11:0] chan_reg,
    input wire chan_full,
    input wire chan_read
);
    // a refused write as seen at the acknowledge edge
    wire wr_nak = ms_we && ms_ack && ms_write_refused;

    // one domain, checks muted while reset is high
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    done_pulse_a: assert property (done |=> !done)
        else $error("done held longer than one cycle");
    done_idle_a: assert property (done |-> !busy && $past(busy))
        else $error("done without a busy period before it");
    req_hold_a: assert property (ms_req && !ms_ack |=> ms_req && $stable(ms_addr))
        else $error("main store request changed before acknowledge");
    pack_top_a: assert property (ms_req && ms_we |-> ms_wdata[63:60] == 4'h0)
        else $error("packed word top bits not zero");
    abs_addr_a: assert property (ms_req && opcode == `PPAG_OP_RD_ONE && !acc[17]
        && $stable(acc) |-> ms_addr == {11'h000, acc[16:0]})
        else $error("absolute address differs from accumulator");
    reloc_low_a: assert property (ms_req && opcode == `PPAG_OP_RD_ONE && acc[17]
        && $stable(acc) |-> ms_addr[5:0] == acc[5:0])
        else $error("relocated address low bits disturbed");
    refuse_set_a: assert property (wr_nak |=> write_refused)
        else $error("refused write not reported");
    refuse_why_a: assert property ($rose(write_refused) |-> $past(wr_nak))
        else $error("refusal reported without refused write");
    chan_hold_a: assert property (chan_full && !chan_read |=> chan_full && $stable(chan_reg))
        else $error("channel word lost before it was read");
    ls_write_a: assert property (ls_we |-> ls_en)
        else $error("local write strobe without enable");
endmodule

bind ppag_core ppag_checker u_chk (.clock, .rst, .opcode, .acc, .busy, .done, .ls_en, .ls_we,
    .ms_req, .ms_we, .ms_addr, .ms_wdata, .ms_ack, .ms_write_refused, .write_refused,
    .chan_reg, .chan_full, .chan_read);

// ---- dv/ppag_ms_model.sv ----
// behavioural main store answering word requests
`timescale 1ns/100ps
module ppag_ms_model (
    // clock and reset
    input wire clock,
    input wire rst,
    // word requests
    input wire ms_req,
    input wire ms_we,
    input wire [27:0] ms_addr,
    input wire [63:0] ms_wdata,
    // answers
    output reg ms_ack,
    output reg ms_write_refused,
    output reg [63:0] ms_rdata,
    // scenario controls and observation
    input wire [3:0] wait_n,
    input wire refuse,
    output reg [63:0] last_wdata
);
    reg [3:0] cnt;

    // one acknowledge per request after wait_n idle cycles
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ms_ack <= 1'b0;
            ms_write_refused <= 1'b0;
            ms_rdata <= 64'h0;
            cnt <= 4'h0;
            last_wdata <= 64'h0;
        end
        else
        begin
            ms_ack <= 1'b0;
            ms_write_refused <= 1'b0;
            ms_rdata <= ~ms_rdata; // released data never keeps its last value
            if (ms_req && !ms_ack && cnt < wait_n)
                cnt <= cnt + 4'h1;
            else if (ms_req && !ms_ack)
            begin
                cnt <= 4'h0;
                ms_ack <= 1'b1;
                ms_rdata <= {ms_addr, ms_addr ^ 28'h5A5A5A5, 8'h3C};
                ms_write_refused <= ms_we && refuse; // only writes are bounded
                if (ms_we)
                    last_wdata <= ms_wdata;
            end
        end
    end
endmodule

// ---- dv/tb.sv ----
// testbench for the address generation core
`timescale 1ns/100ps
`include "ppag_consts.vh"
module tb;
    // stimulus
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg start = 1'b0;
    reg [5:0] opcode = 6'h00;
    reg [2:0] form = 3'h0;
    reg [5:0] d_field = 6'h00;
    reg [11:0] m_field = 12'h000;
    reg [17:0] acc = 18'h00000;
    reg [11:0] block_words = 12'h000;
    reg [11:0] ls_rdata = 12'h000;
    reg [4:0] self_id = 5'h00;
    reg [4:0] peer_id = 5'h00;
    reg pass_valid = 1'b0;
    reg [11:0] pass_data = 12'h000;
    reg chan_read = 1'b0;
    reg refuse = 1'b0;
    reg [3:0] wait_n = 4'h3;
    // observed
    wire [17:0] operand;
    wire [11:0] ls_addr_out, ls_addr, ls_wdata, chan_reg;
    wire busy, done, ls_en, ls_we, ms_req, ms_we, ms_ack, ms_write_refused;
    wire write_refused, pass_ready, chan_full;
    wire [27:0] ms_addr;
    wire [63:0] ms_wdata, ms_rdata, last_wdata;
    // bench state
    reg [11:0] lmem [0:4095];
    reg [11:0] rq [$];
    reg [11:0] wq [$];
    reg [27:0] aq [$];
    reg [27:0] reloc;
    integer n_fail = 0;
    integer checked = 0;
    integer cyc = 0;

    always #5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    ppag_core u_dut (.clock, .rst, .start, .opcode, .form, .d_field, .m_field, .acc,
        .block_words, .operand, .ls_addr_out, .busy, .done, .ls_en, .ls_we, .ls_addr,
        .ls_wdata, .ls_rdata, .ms_req, .ms_we, .ms_addr, .ms_wdata, .ms_ack,
        .ms_write_refused, .ms_rdata, .write_refused, .self_id, .peer_id, .pass_valid,
        .pass_data, .pass_ready, .chan_reg, .chan_full, .chan_read);
    ppag_ms_model u_ms (.clock, .rst, .ms_req, .ms_we, .ms_addr, .ms_wdata, .ms_ack,
        .ms_write_refused, .ms_rdata, .wait_n, .refuse, .last_wdata);

    // local store: read data stands one cycle, then scrambles
    always @(posedge clock)
    begin
        ls_rdata <= ~ls_rdata;
        if (ls_en && ls_we)
        begin
            lmem[ls_addr] <= ls_wdata;
            wq.push_back(ls_wdata);
        end
        else if (ls_en)
        begin
            ls_rdata <= lmem[ls_addr];
            rq.push_back(lmem[ls_addr]);
        end
        if (ms_req && ms_ack)
            aq.push_back(ms_addr);
    end

    task chk(input string what, input [63:0] exp, input [63:0] got);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("wrong value %0s expected %0h seen %0h", what, exp, got);
        end
    end
    endtask

    task wrap_up;
    begin
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    // one instruction: start pulse, then a bounded wait for done
    task run(input [5:0] op, input [2:0] f, input [5:0] d, input [11:0] m, input [11:0] bw);
        integer k;
    begin
        @(negedge clock);
        opcode = op;
        form = f;
        d_field = d;
        m_field = m;
        block_words = bw;
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 3000)
        begin
            @(posedge clock);
            #1;
            k = k + 1;
        end
        chk("done", 1'b1, done);
    end
    endtask

    // small relocation words: spare top bits clear, bit 4 set, low four bits from the address
    task fill;
        integer i;
    begin
        for (i = 0; i < 4096; i = i + 1)
            lmem[i] = {7'h00, 1'b1, i[3:0]};
        rq.delete();
        wq.delete();
        aq.delete();
    end
    endtask

    task t_forms;
    begin
        run(6'h00, `PPAG_FORM_NOADDR, 6'h2A, 12'hFFF, 12'h000);
        chk("imm6", 18'h0002A, operand);
        run(6'h00, `PPAG_FORM_CONST, 6'h35, 12'hABC, 12'h000);
        chk("imm18", 18'h35ABC, operand);
        run(6'h00, `PPAG_FORM_DIRECT, 6'h3F, 12'h777, 12'h000);
        chk("direct", 12'h03F, ls_addr_out);
        run(6'h00, `PPAG_FORM_INDEXED, 6'h00, 12'hE21, 12'h000);
        chk("idx zero", 12'hE21, ls_addr_out);
        lmem[7] = 12'h9C4;
        run(6'h00, `PPAG_FORM_INDIRECT, 6'h07, 12'h000, 12'h000);
        chk("indirect", 12'h9C4, ls_addr_out);
    end
    endtask

    task idx(input [11:0] m, input [11:0] ix, input [11:0] exp);
    begin
        lmem[9] = ix;
        run(6'h00, `PPAG_FORM_INDEXED, 6'h09, m, 12'h000);
        chk("indexed", exp, ls_addr_out);
    end
    endtask

    task t_reloc;
        reg [11:0] hi, lo;
    begin
        fill;
        run(`PPAG_OP_LOAD_RELOC, `PPAG_FORM_DIRECT, 6'h10, 12'h000, 12'h000);
        chk("reloc reads", 2, rq.size());
        hi = lmem[0];
        lo = lmem[1];
        reloc = {hi, lo[11:2], 6'h00};
        acc = {1'b1, 17'h00345};
        run(`PPAG_OP_RD_ONE, `PPAG_FORM_DIRECT, 6'h00, 12'h100, 12'h000);
        chk("reloc addr", reloc + 28'h0000345, aq[0]);
        wq.delete();
        run(`PPAG_OP_STORE_RELOC, `PPAG_FORM_DIRECT, 6'h12, 12'h000, 12'h000);
        chk("store hi", hi, wq[0]);
        chk("store lo", lo & 12'hFFC, wq[1]);
    end
    endtask

    task t_read;
        reg [63:0] w;
        integer k;
    begin
        fill;
        acc = 18'h0ABCD;
        w = {28'h000ABCD, 28'h000ABCD ^ 28'h5A5A5A5, 8'h3C};
        run(`PPAG_OP_RD_ONE, `PPAG_FORM_DIRECT, 6'h00, 12'h200, 12'h000);
        chk("abs addr", 28'h000ABCD, aq[0]);
        chk("unpack n", 5, wq.size());
        for (k = 0; k < 5; k = k + 1)
            chk("unpack", w[59 - 12 * k -: 12], wq[k]);
    end
    endtask

    // block read, then a mode flip between its two words
    task t_block;
    begin
        fill;
        wait_n = 4'h0;
        acc = 18'h00100;
        run(`PPAG_OP_RD_BLK, `PPAG_FORM_DIRECT, 6'h00, 12'hFFE, 12'h003);
        chk("blk reqs", 3, aq.size());
        chk("blk words", 15, wq.size());
        acc = {1'b1, 17'h00010};
        aq.delete();
        fork
            run(`PPAG_OP_RD_BLK, `PPAG_FORM_DIRECT, 6'h00, 12'h300, 12'h002);
            begin
                @(posedge clock iff (ms_ack === 1'b1));
                @(negedge clock);
                acc[17] = 1'b0;
            end
        join
        chk("mode rel", 1'b1, aq[0][27:18] != 10'h000);
        chk("mode abs", 1'b1, aq[1][27:18] == 10'h000);
        wait_n = 4'h3;
    end
    endtask

    task t_write;
    begin
        fill;
        acc = 18'h00777;
        run(`PPAG_OP_WR_ONE, `PPAG_FORM_DIRECT, 6'h00, 12'h040, 12'h000);
        chk("pack", {4'h0, lmem[64], lmem[65], lmem[66], lmem[67], lmem[68]}, last_wdata);
        chk("no refuse", 1'b0, write_refused);
        refuse = 1'b1;
        run(`PPAG_OP_WR_ONE, `PPAG_FORM_DIRECT, 6'h00, 12'h040, 12'h000);
        chk("refused", 1'b1, write_refused);
        run(`PPAG_OP_RD_ONE, `PPAG_FORM_DIRECT, 6'h00, 12'h040, 12'h000);
        chk("refuse clr", 1'b0, write_refused); // reads never refused
        refuse = 1'b0;
        aq.delete();
        run(`PPAG_OP_WR_BLK, `PPAG_FORM_DIRECT, 6'h00, 12'hFFD, 12'h002);
        chk("wblk reqs", 2, aq.size());
    end
    endtask

    // fill the channel buffer until it refuses, drain it, time the last load
    task pace(input [4:0] s, input [4:0] p, input integer lo);
        integer n, k, w, t0, t1;
        reg r;
    begin
        self_id = s;
        peer_id = p;
        n = 0;
        t1 = 0;
        @(negedge clock);
        pass_valid = 1'b1;
        pass_data = 12'hA00;
        for (k = 0; k < 24; k = k + 1)
        begin
            r = pass_ready;
            @(negedge clock);
            if (r === 1'b1)
                n = n + 1;
            pass_data = 12'hA00 + n;
        end
        pass_valid = 1'b0;
        chk("fill", 1'b1, n >= 8 && n <= 9);
        for (k = 0; k < n; k = k + 1)
        begin
            w = 0;
            while (chan_full !== 1'b1 && w < 100)
            begin
                @(posedge clock);
                #1;
                w = w + 1;
            end
            chk("chan data", 12'hA00 + k, chan_reg);
            t0 = t1;
            t1 = cyc;
            @(negedge clock);
            chan_read = 1'b1;
            @(negedge clock);
            chan_read = 1'b0;
        end
        chk("pace", 1'b1, (t1 - t0) >= lo && (t1 - t0) < lo + 25);
    end
    endtask

    initial
    begin
        fill;
        repeat (20) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        t_forms;
        idx(12'h005, 12'hFFE, 12'h004);
        idx(12'h100, 12'h050, 12'h150);
        idx(12'h001, 12'hFFE, 12'h000);
        idx(12'hFFF, 12'hFFF, 12'hFFF);
        t_reloc;
        t_read;
        t_block;
        t_write;
        pace(5'h00, 5'h01, 25);
        pace(5'h00, 5'h05, 25);
        pace(5'h00, 5'h10, 50);
        pace(5'h04, 5'h14, 50);
        wrap_up;
    end

    // watchdog well past the expected run length
    initial
    begin
        repeat (40000) @(posedge clock);
        n_fail = n_fail + 1;
        wrap_up;
    end
endmodule
